/* codec_link_model.sv */
/*
 Codec side of the serial link: raw root clock, divider frame sync, pin.
 Assumes the bench commands the frame-sync level it wants on the pin.
*/
`timescale 1ns/1ps
`default_nettype none
module codec_link_model (
   // Clock, reset and frame level request.
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic fs_level,
   // Link lines.
   output logic      root_clk_raw,
   output logic      fs_divider,
   output logic      fs_pin
);
   logic [3:0] cnt_q;
   // Free-running divider; the pin lags its command by one cycle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 4'h0;
         fs_pin <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
         fs_pin <= fs_level;
      end
   end
   assign root_clk_raw = cnt_q[1];
   assign fs_divider = cnt_q[3];
endmodule // codec_link_model
`default_nettype wire

/* codec_port_irq_clock_ctrl.sv */
/*
 Interrupt status, enables and glitch-free clock gating for a serial codec
 port. Assumes the divider, FIFOs and DMA engine sit outside and report their
 events and levels as single-cycle pulses or levels on the system clock; the
 frame-sync pin is asynchronous and passes a three-stage synchroniser.
*/
// What this block does
// [R1] Frame-sync interrupt uses falling edge when edge select set, else rising.
// [R2] Set frame-sync-stopped status when a stop completes; write one clears.
// [R3] Setting frame-sync enable clears frame-sync-stopped status.
// [R4] Receive level status follows level at or above threshold while enabled.
// [R5] Receive overflow sets sticky status when receiver enabled; write one clears.
// [R6] DMA-complete status sets with transmit and DMA enabled; write one clears.
// [R7] DMA completes when count expires and other buffer is off or finished.
// [R8] Buffer one finished status blocks buffer reuse until cleared by one.
// [R9] Buffer two finished status blocks buffer reuse until cleared by one.
// [R10] Transmit level status follows empty count at or above threshold.
// [R11] Software uses transmit level status only outside DMA mode.
// [R12] In DMA mode an empty FIFO sets out-of-data, no pop, zeros sent.
// [R13] Out-of-data status is raised only in DMA mode.
// [R14] Transmit complete sets on empty FIFO plus DMA-complete in DMA mode.
// [R15] Frame-sync status sets on the selected edge; write one clears.
// [R16] Edge select zero picks rising edge, one picks falling edge.
// [R17] Root clock stops only while low and is then held low.
// [R18] Software programs dividers, waits one bit period, then enables bit clock.
// [R19] Frame-sync enable changes only when divider frame sync is at stop level.
// [R20] Software writes zero to reserved status positions.
// [R21] Writing zero leaves status unchanged; low half holds enables.
// [R22] Status bits set regardless of their interrupt enables.
// [R23] Interrupt output is high while any enabled status bit is set.
`timescale 1ns/1ps
`default_nettype none
module codec_port_irq_clock_ctrl
   import codec_port_pkg::*;
(
   // Clock, reset and clock enable.
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // AXI4-Lite slave.
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Control from the transmit and receive control registers.
   input  wire logic        tx_enable,
   input  wire logic        tx_dma_enable,
   input  wire logic        buf1_enable,
   input  wire logic        buf2_enable,
   input  wire logic        rx_enable,
   input  wire logic        fs_stop_level,
   input  wire logic        fs_is_output,
   // FIFO and DMA events.
   input  wire logic        rx_at_threshold,
   input  wire logic        rx_overflow,
   input  wire logic        tx_empty_at_threshold,
   input  wire logic        tx_fifo_empty,
   input  wire logic        tx_frame_need,
   input  wire logic        buf1_count_expired,
   input  wire logic        buf2_count_expired,
   // Clocks and frame sync from the divider and the pin.
   input  wire logic        root_clk_raw,
   input  wire logic        fs_divider,
   input  wire logic        fs_pin,
   // Gated outputs.
   output logic             root_clk_gated,
   output logic             bit_clk_enable,
   output logic             fs_out,
   output logic             tx_pop,
   output logic             tx_send_zero,
   output logic             buf1_usable,
   output logic             buf2_usable,
   output logic             irq
);

   // Status, enables and clock controls.
   logic [31:16] status_q;
   logic [31:16] status_d;
   logic [15:0]  enable_q;
   logic [3:0]   clk_en_q;
   logic         root_run_q;
   logic         fs_run_q;
   logic         fs_stopping_q;
   logic [2:0]   fs_sync_q;
   logic         fs_level_q;

   // Bus handshake state.
   logic         aw_held_q;
   logic         w_held_q;
   logic [11:0]  awaddr_q;
   logic [31:0]  wdata_q;
   logic [3:0]   wstrb_q;

   // Write one to a sticky status bit clears it; zero leaves it alone.
   function automatic logic [31:0] byte_mask(input logic [3:0] strb);
      byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction

   // Write decode.
   wire        wr_fire     = aw_held_q && w_held_q && !s_axi_bvalid && ce;
   wire [31:0] wr_bits     = wdata_q & byte_mask(wstrb_q);
   wire        wr_irq_reg  = wr_fire && (awaddr_q == OFF_IRQ_CTRL_STATUS);
   wire        wr_clk_reg  = wr_fire && (awaddr_q == OFF_CLK_EN_EDGE_SEL);
   wire        wr_known    = (awaddr_q == OFF_IRQ_CTRL_STATUS) ||
                             (awaddr_q == OFF_CLK_EN_EDGE_SEL) ||
                             (awaddr_q == OFF_PORT_STATE);
   wire [31:0] w1c         = wr_irq_reg ? (wr_bits & STATUS_W1C) : 32'h0; // R21

   // Frame-sync edges, seen only after stages two and three agree.
   wire fs_now     = fs_sync_q[2];
   wire fs_agree   = (fs_sync_q[1] == fs_sync_q[2]);
   wire fs_rise    = fs_agree && fs_now && !fs_level_q;
   wire fs_fall    = fs_agree && !fs_now && fs_level_q;
   wire fs_sel_hit = clk_en_q[CE_EDGE] ? fs_fall : fs_rise; // R1 R16

   // Transmit and DMA qualification.
   wire dma_mode   = tx_enable && tx_dma_enable;
   wire b1_end     = dma_mode && buf1_enable && buf1_count_expired;
   wire b2_end     = dma_mode && buf2_enable && buf2_count_expired;
   wire dma_done   = (b1_end && (!buf2_enable || status_q[ST_BUF2_DONE])) ||
                     (b2_end && (!buf1_enable || status_q[ST_BUF1_DONE])); // R7
   wire underrun   = dma_mode && tx_fifo_empty && tx_frame_need; // R12 R13
   wire tx_finish  = tx_enable && tx_fifo_empty &&
                     (!tx_dma_enable || status_q[ST_DMA_DONE]); // R14
   wire fs_en_set  = wr_clk_reg && wr_bits[CE_FS] && !clk_en_q[CE_FS];
   wire fs_at_stop = (fs_divider == fs_stop_level);
   wire fs_stop_ok = fs_stopping_q && fs_at_stop && fs_is_output;

   // Next status: set wins over a write-one clear for sticky bits.
   always_comb begin
      status_d = status_q & ~w1c[31:16];
      if (fs_stop_ok)  status_d[ST_FS_STOPPED] = 1'b1; // R2 R22
      if (fs_en_set || clk_en_q[CE_FS]) status_d[ST_FS_STOPPED] = 1'b0; // R3
      status_d[ST_RX_LEVEL] = rx_enable && rx_at_threshold; // R4
      if (rx_enable && rx_overflow) status_d[ST_RX_OVF] = 1'b1; // R5
      if (dma_done)    status_d[ST_DMA_DONE]  = 1'b1; // R6
      if (b1_end)      status_d[ST_BUF1_DONE] = 1'b1; // R8
      if (b2_end)      status_d[ST_BUF2_DONE] = 1'b1; // R9
      status_d[ST_TX_LEVEL] = tx_empty_at_threshold; // R10
      if (underrun)    status_d[ST_TX_NODATA] = 1'b1; // R12
      if (tx_finish)   status_d[ST_TX_DONE]   = 1'b1; // R14
      if (fs_sel_hit)  status_d[ST_FS_EDGE]   = 1'b1; // R15
      status_d[21]    = 1'b0;
      status_d[19:16] = 4'h0;
      status_d[30]    = 1'b0;
   end

   // Status and enable registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_q <= 16'h0;
         enable_q <= ENABLE_RESET;
         clk_en_q <= CLK_EN_RESET;
      end else if (ce) begin
         status_q <= status_d;
         if (wr_irq_reg) enable_q <= wr_bits[15:0] & ENABLE_MASK; // R21
         if (wr_clk_reg) clk_en_q <= wr_bits[3:0];
      end
   end

   // Frame-sync synchroniser; the first stage feeds only the second.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fs_sync_q  <= 3'h0;
         fs_level_q <= 1'b0;
      end else if (ce) begin
         fs_sync_q <= {fs_sync_q[1:0], fs_pin};
         if (fs_agree) fs_level_q <= fs_now;
      end
   end

   // Root clock gate: the enable only moves while the raw clock is low,
   // so neither a stop nor a start can cut a high phase short.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         root_run_q <= 1'b0;
      end else if (ce && !root_clk_raw) begin
         root_run_q <= clk_en_q[CE_ROOT]; // R17
      end
   end
   assign root_clk_gated = root_clk_raw & root_run_q; // R17

   // Frame-sync gate: start and stop only at the programmed stop level.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fs_run_q      <= 1'b0;
         fs_stopping_q <= 1'b0;
      end else if (ce) begin
         if (fs_at_stop) fs_run_q <= clk_en_q[CE_FS]; // R19
         fs_stopping_q <= !clk_en_q[CE_FS] &&
                          (fs_run_q || fs_stopping_q) && !fs_stop_ok;
      end
   end

   // Frame sync output sits at the stop level whenever gated off.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fs_out <= 1'b0;
      end else if (ce) begin
         fs_out <= fs_run_q ? fs_divider : fs_stop_level; // R19
      end
   end

   // Bit clock enable is a plain control; clean start is software's job.
   assign bit_clk_enable = clk_en_q[CE_BIT]; // R18

   // Transmit pop control and buffer reuse gating.
   assign tx_pop       = tx_enable && tx_frame_need && !tx_fifo_empty; // R12
   assign tx_send_zero = tx_enable && tx_frame_need && tx_fifo_empty; // R12
   assign buf1_usable  = buf1_enable && !status_q[ST_BUF1_DONE]; // R8
   assign buf2_usable  = buf2_enable && !status_q[ST_BUF2_DONE]; // R9

   // Interrupt output: status gated by the enable sixteen places lower.
   assign irq = |(status_q & enable_q); // R23

   // Write address and data are latched independently, in either order.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held_q    <= 1'b0;
         w_held_q     <= 1'b0;
         awaddr_q     <= 12'h0;
         wdata_q      <= 32'h0;
         wstrb_q      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= {s_axi_awaddr[11:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid && ce;
   assign s_axi_wready  = !w_held_q && !s_axi_bvalid && ce;

   // Read decode; the third word shows the live gate and pin state.
   wire [11:0] rd_addr  = {s_axi_araddr[11:2], 2'h0};
   wire        rd_irq   = (rd_addr == OFF_IRQ_CTRL_STATUS);
   wire        rd_clk   = (rd_addr == OFF_CLK_EN_EDGE_SEL);
   wire        rd_state = (rd_addr == OFF_PORT_STATE);
   wire [31:0] rd_mux   = rd_irq ? {status_q, enable_q} :
                          rd_clk ? {28'h0, clk_en_q} :
                          rd_state ? {28'h0, fs_level_q, fs_stopping_q,
                                      fs_run_q, root_run_q} : 32'h0;

   // Read channel: one cycle from address to data.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= (rd_irq || rd_clk || rd_state) ?
                            RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   assign s_axi_arready = !s_axi_rvalid && ce;

endmodule // codec_port_irq_clock_ctrl
`default_nettype wire

/* codec_port_pkg.sv */
/*
 Package for the codec port interrupt status and clock enable block.
 Holds register offsets, field positions and reset values.
 Assumes a 32-bit AXI4-Lite register bus and a 40 MHz system clock.
*/
package codec_port_pkg;
   // Register byte offsets.
   localparam logic [11:0] OFF_IRQ_CTRL_STATUS = 12'h284;
   localparam logic [11:0] OFF_CLK_EN_EDGE_SEL = 12'h290;
   localparam logic [11:0] OFF_PORT_STATE      = 12'h298;
   // Status bit positions.
   localparam int ST_FS_STOPPED = 20;
   localparam int ST_RX_LEVEL   = 22;
   localparam int ST_RX_OVF     = 23;
   localparam int ST_DMA_DONE   = 24;
   localparam int ST_BUF1_DONE  = 25;
   localparam int ST_BUF2_DONE  = 26;
   localparam int ST_TX_LEVEL   = 27;
   localparam int ST_TX_NODATA  = 28;
   localparam int ST_TX_DONE    = 29;
   localparam int ST_FS_EDGE    = 31;
   // Clock enable register bit positions.
   localparam int CE_ROOT = 0;
   localparam int CE_BIT  = 1;
   localparam int CE_FS   = 2;
   localparam int CE_EDGE = 3;
   // Writable masks and reset values.
   localparam logic [15:0] ENABLE_MASK   = 16'h bfd0;
   localparam logic [31:0] STATUS_W1C    = 32'h b7900000;
   localparam logic [15:0] ENABLE_RESET  = 16'h0000;
   localparam logic [3:0]  CLK_EN_RESET  = 4'h0;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

/* codec_port_properties.sv */
/*
 Checker for the codec port status and clock block.
 Sees only the top module's ports; bound in below the module.
*/
`timescale 1ns/1ps
`default_nettype none
module codec_port_properties (
   // Clock, reset and run enable.
   input wire logic clk, rst, ce,
   // Write handshakes.
   input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid,
   input wire logic s_axi_wready, s_axi_bvalid,
   // Transmit and DMA.
   input wire logic tx_enable, tx_dma_enable, tx_fifo_empty,
   input wire logic tx_frame_need, tx_pop, tx_send_zero,
   input wire logic buf1_enable, buf2_enable, buf1_usable, buf2_usable,
   input wire logic buf1_count_expired, buf2_count_expired,
   // Clocks.
   input wire logic root_clk_raw, root_clk_gated, bit_clk_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Both halves of a write accepted at one edge.
   sequence wr_taken;
      ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence dma_on;
      ce && tx_enable && tx_dma_enable;
   endsequence
   a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response missing");
   a_dma_no_pop: assert property (dma_on ##0 (tx_frame_need &&
      tx_fifo_empty) |-> !tx_pop && tx_send_zero) else $error("empty popped");
   a_word_popped: assert property (tx_enable && tx_frame_need &&
      !tx_fifo_empty |-> tx_pop && !tx_send_zero) else $error("pop missing");
   a_buf1_held: assert property (dma_on ##0 (buf1_enable &&
      buf1_count_expired) |=> !buf1_usable) else $error("buffer 1 reused");
   a_buf2_held: assert property (dma_on ##0 (buf2_enable &&
      buf2_count_expired) |=> !buf2_usable) else $error("buffer 2 reused");
   a_root_rise: assert property ($rose(root_clk_gated)
      |-> $rose(root_clk_raw)) else $error("root clock short start");
   a_root_fall: assert property ($fell(root_clk_gated)
      |-> $fell(root_clk_raw)) else $error("root clock short stop");
   a_bitclk_write: assert property ($changed(bit_clk_enable)
      |-> $rose(s_axi_bvalid)) else $error("bit clock moved alone");
endmodule // codec_port_properties
bind codec_port_irq_clock_ctrl codec_port_properties u_props (.*);
`default_nettype wire

/* tb_codec_port_irq_clock_ctrl.sv */
/*
 Self-checking bench for the codec port status and clock block.
 Drives the register bus and events; the codec model drives the link.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
   $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_codec_port_irq_clock_ctrl;
   import codec_port_pkg::*;
   logic clk = 0, rst = 1, ce = 1, fs_level = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic tx_enable = 0, tx_dma_enable = 0, buf1_enable = 0, buf2_enable = 0;
   logic rx_enable = 0, fs_stop_level = 0, fs_is_output = 0;
   logic rx_at_threshold = 0, rx_overflow = 0, tx_empty_at_threshold = 0;
   logic tx_fifo_empty = 0, tx_frame_need = 0;
   logic buf1_count_expired = 0, buf2_count_expired = 0;
   logic root_clk_raw, fs_divider, fs_pin, root_clk_gated, bit_clk_enable;
   logic fs_out, tx_pop, tx_send_zero, buf1_usable, buf2_usable, irq;
   int fails = 0, check_count = 0;
   logic [33:0] exp_q[$];
   localparam logic [11:0] ST = OFF_IRQ_CTRL_STATUS;
   localparam logic [11:0] CK = OFF_CLK_EN_EDGE_SEL;
   // Half period of 12.5 ns gives the 40 MHz clock.
   always #12.5 clk = ~clk;
   codec_port_irq_clock_ctrl u_codec_port_irq_clock_ctrl (.*);
   codec_link_model u_codec_link_model (.*);
   logic [33:0] exp_v;
   // Each answer is matched against the oldest noted expectation; the note
   // is taken off once, since the macro reads its arguments twice.
   always @(posedge clk) begin
      if (s_axi_bvalid && s_axi_bready) begin
         exp_v = exp_q.pop_front();
         `CHK({s_axi_bresp, 32'h0}, exp_v)
      end
      if (s_axi_rvalid && s_axi_rready) begin
         exp_v = exp_q.pop_front();
         `CHK({s_axi_rresp, s_axi_rdata}, exp_v)
      end
   end
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // A wait that ran out is a mismatch and ends the run.
   task automatic tmo(input int n);
      if (n >= 50) begin fails++; tally_and_finish; end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      exp_q.push_back({RESP_OKAY, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (n < 50 && !s_axi_bvalid);
      tmo(n);
      s_axi_bready <= 0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      int n;
      exp_q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (n < 50 && !s_axi_rvalid);
      tmo(n);
      s_axi_rready <= 0;
      @(posedge clk);
   endtask
   // Main sequence.
   initial begin
      logic [31:0] r;
      r = $urandom(83948);
      repeat (4) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      rd(ST, 34'h0);
      rd(12'h2a0, {RESP_SLVERR, 32'h0});
      r = $urandom;
      wr(ST, {16'h0, r[15:0]});
      rd(ST, {18'h0, r[15:0] & ENABLE_MASK});
      wr(ST, 32'h0);
      rx_enable <= 1;
      rx_overflow <= 1;
      @(posedge clk);
      rx_overflow <= 0;
      rd(ST, 34'h00800000);
      `CHK(irq, 1'b0)
      wr(ST, 32'h00000080);
      rd(ST, 34'h00800080);
      `CHK(irq, 1'b1)
      wr(ST, 32'h00800080);
      rd(ST, 34'h00000080);
      rx_at_threshold <= 1;
      tx_empty_at_threshold <= 1;
      @(posedge clk);
      rd(ST, 34'h08400080);
      rx_enable <= 0;
      tx_empty_at_threshold <= 0;
      @(posedge clk);
      rd(ST, 34'h00000080);
      // Two-buffer DMA with an underrun before completion.
      {tx_enable, tx_dma_enable, buf1_enable, buf2_enable} <= 4'hf;
      tx_fifo_empty <= 1;
      @(posedge clk);
      tx_frame_need <= 1;
      buf1_count_expired <= 1;
      @(posedge clk);
      `CHK({tx_pop, tx_send_zero}, 2'b01)
      tx_frame_need <= 0;
      buf1_count_expired <= 0;
      @(posedge clk);
      rd(ST, 34'h12000080);
      `CHK({buf1_usable, buf2_usable}, 2'b01)
      buf2_count_expired <= 1;
      @(posedge clk);
      buf2_count_expired <= 0;
      // Transmit complete follows DMA complete by one cycle.
      @(posedge clk);
      rd(ST, 34'h37000080);
      tx_fifo_empty <= 0;
      wr(ST, 32'h37000080);
      rd(ST, 34'h00000080);
      `CHK({buf1_usable, buf2_usable}, 2'b11)
      // Frame-sync status under each edge selection.
      for (int e = 0; e < 2; e++) begin
         wr(CK, {28'h0, e[0], 3'h0});
         fs_level <= 1;
         repeat (8) @(posedge clk);
         rd(ST, {2'h0, (e[0] ? 32'h0 : 32'h80000000)} | 34'h80);
         fs_level <= 0;
         repeat (8) @(posedge clk);
         rd(ST, 34'h80000080);
         wr(ST, 32'h80000080);
      end
      // Bit clock after the root clock runs; then a frame-sync stop.
      fs_is_output <= 1;
      fs_stop_level <= 1;
      wr(CK, 32'h5);
      repeat (16) @(posedge clk);
      wr(CK, 32'h7);
      `CHK(bit_clk_enable, 1'b1)
      repeat (40) @(posedge clk);
      wr(CK, 32'h3);
      repeat (40) @(posedge clk);
      rd(ST, 34'h00100080);
      `CHK(fs_out, 1'b1)
      rd(OFF_PORT_STATE, 34'h1);
      wr(CK, 32'h7);
      rd(ST, 34'h00000080);
      wr(CK, 32'h0);
      repeat (8) @(posedge clk);
      `CHK(root_clk_gated, 1'b0)
      tally_and_finish;
   end
endmodule // tb_codec_port_irq_clock_ctrl
`default_nettype wire
